/* pkg/ledcfg_if.sv */
// Purpose: Write port between the bus slave and the configuration store
// Assumes: One clock domain
// Notes: Write data is already merged into a full 48-bit word
interface ledcfg_if;
    logic we1;
    logic we2;
    logic [47:0] wdata;
    logic [47:0] cfg1;
    logic [47:0] cfg2;
    modport master (output we1, output we2, output wdata, input cfg1, input cfg2);
    modport store (input we1, input we2, input wdata, output cfg1, output cfg2);
endinterface : ledcfg_if

/* pkg/ledcfg_pkg.sv */
// Purpose: Shared constants for the LED matrix timing configuration registers
// Assumes: APB with 32-bit data; each 48-bit word split into low and high halves
// Notes: Offsets are byte addresses of aligned words
package ledcfg_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_CFG1_LO = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_CFG1_HI = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_CFG2_LO = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_CFG2_HI = 4'hC;
    localparam int unsigned WORD_W = 48;
    localparam int unsigned HI_W = 16;
    // Reset images of both words, reserved bits included
    localparam logic [WORD_W-1:0] CFG1_RESET = 48'h00E0_0094_A400;
    localparam logic [WORD_W-1:0] CFG2_RESET = 48'h0380_0000_0666;
    // Writable bit masks; zero bits are reserved and hold their reset value
    localparam logic [WORD_W-1:0] CFG1_WMASK = 48'h7FFF_FFFF_FFFF;
    localparam logic [WORD_W-1:0] CFG2_WMASK = 48'h8F8F_FFFF_FFFF;
    // Decode constants: the long segment length code, then decoded clock counts and limits
    localparam logic [9:0] SEG_CODE_LONG = 10'h3FF;
    localparam logic [10:0] SEG_CLK_SHORT = 11'h080;
    localparam logic [10:0] SEG_CLK_LONG = 11'h400;
    localparam logic [8:0] LINE_SW_ZERO_CLK = 9'h02D;
    localparam logic [8:0] LINE_SW_UNIT_CLK = 9'h01E;
    localparam logic [8:0] SUBP_LIMIT_EXT = 9'h100;
    localparam logic [8:0] SUBP_LIMIT_NORM = 9'h080;
endpackage : ledcfg_pkg

/* rtl/ledcfg_regs.sv */
// Operation
// R1 - Segment length code 1023 gives 1024 grayscale clocks, any other code 128, reset 0.
// R2 - Each colour smoothing code maps to level code plus one, resetting to 01001.
// R3 - Each colour boost code selects a level equal to the code, resetting to 0.
// R4 - Line switch code 0 gives 45 clocks, code n gives (n+1)*30, reset 0111.
// R5 - Black field code inserts its binary value in clocks, reset 0.
// R6 - Red pre-discharge code picks 0.1V to 2.1V, reset 0110; keep it under supply minus 1.3V.
// R7 - Green and blue pre-discharge codes use the same scale and reset to 0110.
// R8 - The subperiod extend bit raises the limit to 256, reset clear.
// R9 - The module size bit picks 16x16 at 0 and 32x32 at 1, reset 0.
// R10 - Each colour noise bit picks high immunity at 0, low at 1, resetting to 1.
// R11 - Reserved bits read reset values and ignore writes; writable fields hold their value.
// Purpose: APB register bank for the scan timing and pre-discharge configuration words
// Assumes: Zero wait state APB slave; low half at base, high 16 bits at base+4
// Notes: High-half write merges with the stored low half, so halves may be written separately
module ledcfg_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ledcfg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Scan timing outputs
    output logic [10:0] segment_clock_count,
    output logic [8:0] scan_line_switch_time,
    output logic [5:0] black_field_clocks,
    output logic [5:0] red_lowgray_smoothing,
    output logic [5:0] green_lowgray_smoothing,
    output logic [5:0] blue_lowgray_smoothing,
    output logic [3:0] red_lowgray_boost,
    output logic [3:0] green_lowgray_boost,
    output logic [3:0] blue_lowgray_boost,
    // Colour outputs, then subperiod limit, module size and power saving
    output logic [3:0] red_predischarge_code,
    output logic [3:0] green_predischarge_code,
    output logic [3:0] blue_predischarge_code,
    output logic [3:0] red_decoupling_level,
    output logic [3:0] green_decoupling_level,
    output logic [3:0] blue_decoupling_level,
    output logic [3:0] red_lowgray_compensation,
    output logic [3:0] green_lowgray_compensation,
    output logic [3:0] blue_lowgray_compensation,
    output logic red_group_noise_setting,
    output logic green_group_noise_setting,
    output logic blue_group_noise_setting,
    output logic [8:0] subperiod_limit,
    output logic module_dimension_select,
    output logic matrix_power_saving_enable
);
    import ledcfg_pkg::*;

    ledcfg_if cfg_bus ();
    ledcfg_store u_store (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .cfg(cfg_bus.store)
    );

    logic [WORD_W-1:0] cfg1, cfg2;
    assign cfg1 = cfg_bus.cfg1;
    assign cfg2 = cfg_bus.cfg2;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a == OFF_CFG1_LO) || (a == OFF_CFG1_HI)
            || (a == OFF_CFG2_LO) || (a == OFF_CFG2_HI);
    endfunction : addr_hit

    logic wr_acc;
    logic [31:0] rd_nxt, prdata_r;
    assign wr_acc = psel && penable && pwrite && addr_hit(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit(paddr);

    always_comb begin
        cfg_bus.we1 = 1'b0;
        cfg_bus.we2 = 1'b0;
        cfg_bus.wdata = cfg1;
        case (paddr)
            OFF_CFG1_LO: begin
                cfg_bus.we1 = wr_acc;
                cfg_bus.wdata = {cfg1[WORD_W-1:32], pwdata};
            end
            OFF_CFG1_HI: begin
                cfg_bus.we1 = wr_acc;
                cfg_bus.wdata = {pwdata[HI_W-1:0], cfg1[31:0]};
            end
            OFF_CFG2_LO: begin
                cfg_bus.we2 = wr_acc;
                cfg_bus.wdata = {cfg2[WORD_W-1:32], pwdata};
            end
            OFF_CFG2_HI: begin
                cfg_bus.we2 = wr_acc;
                cfg_bus.wdata = {pwdata[HI_W-1:0], cfg2[31:0]};
            end
            default: begin
                cfg_bus.wdata = cfg1;
            end
        endcase
    end

    // Read data registered at setup so it is stable through the access phase
    always_comb begin
        rd_nxt = prdata_r;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                OFF_CFG1_LO: rd_nxt = cfg1[31:0];
                OFF_CFG1_HI: rd_nxt = {16'h0000, cfg1[WORD_W-1:32]};
                OFF_CFG2_LO: rd_nxt = cfg2[31:0];
                OFF_CFG2_HI: rd_nxt = {16'h0000, cfg2[WORD_W-1:32]};
                default: rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prdata_r <= 32'h0000_0000;
        end else begin
            prdata_r <= rd_nxt;
        end
    end
    assign prdata = prdata_r;

    // Field decode; registered copies would only add latency to static settings
    assign segment_clock_count = (cfg1[9:0] == SEG_CODE_LONG) ?
        SEG_CLK_LONG : SEG_CLK_SHORT; // R1
    assign red_lowgray_smoothing = {1'b0, cfg1[14:10]} + 6'h01; // R2
    assign green_lowgray_smoothing = {1'b0, cfg1[19:15]} + 6'h01; // R2
    assign blue_lowgray_smoothing = {1'b0, cfg1[24:20]} + 6'h01; // R2
    assign red_lowgray_boost = cfg1[28:25]; // R3
    assign green_lowgray_boost = cfg1[32:29]; // R3
    assign blue_lowgray_boost = cfg1[36:33]; // R3
    assign scan_line_switch_time = (cfg1[40:37] == 4'h0) ? LINE_SW_ZERO_CLK :
        9'((cfg1[40:37] + 5'h01) * LINE_SW_UNIT_CLK); // R4
    assign black_field_clocks = cfg1[46:41]; // R5
    assign red_predischarge_code = cfg2[3:0]; // R6
    assign green_predischarge_code = cfg2[7:4]; // R7
    assign blue_predischarge_code = cfg2[11:8]; // R7
    assign red_decoupling_level = cfg2[15:12];
    assign green_decoupling_level = cfg2[19:16];
    assign blue_decoupling_level = cfg2[23:20];
    assign red_lowgray_compensation = cfg2[27:24];
    assign green_lowgray_compensation = cfg2[31:28];
    assign blue_lowgray_compensation = cfg2[35:32];
    assign red_group_noise_setting = cfg2[39]; // R10
    assign green_group_noise_setting = cfg2[40]; // R10
    assign blue_group_noise_setting = cfg2[41]; // R10
    assign subperiod_limit = cfg2[42] ? SUBP_LIMIT_EXT : SUBP_LIMIT_NORM; // R8
    assign module_dimension_select = cfg2[43]; // R9
    assign matrix_power_saving_enable = cfg2[47];

    a_seg_decode: assert property (@(posedge ref_clk) disable iff (!rstn)
        segment_clock_count == ((cfg1[9:0] == 10'h3FF) ? 11'h400 : 11'h080)) // R1
        else $error("segment count wrong");
    a_smooth_decode: assert property (@(posedge ref_clk) disable iff (!rstn)
        red_lowgray_smoothing - 6'h01 == {1'b0, cfg1[14:10]}) // R2
        else $error("smoothing level wrong");
    a_boost_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_acc && paddr == OFF_CFG1_LO |=> red_lowgray_boost == $past(pwdata[28:25])) // R3
        else $error("boost not written");
    a_line_sw: assert property (@(posedge ref_clk) disable iff (!rstn)
        cfg1[40:37] == 4'hF |-> scan_line_switch_time == 9'h1E0) // R4
        else $error("line switch wrong");
    a_black_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_acc && paddr == OFF_CFG1_HI |=> black_field_clocks == $past(pwdata[14:9])) // R5
        else $error("black field not written");
    a_pdc_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_acc && paddr == OFF_CFG2_LO |=> {blue_predischarge_code,
        green_predischarge_code, red_predischarge_code} == $past(pwdata[11:0])) // R6
        else $error("predischarge not written");
    a_subp_limit: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_acc && paddr == OFF_CFG2_HI && pwdata[10] |=> subperiod_limit == 9'h100) // R8
        else $error("subperiod limit wrong");
    a_size_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_acc && paddr == OFF_CFG2_HI |=> module_dimension_select == $past(pwdata[11])) // R9
        else $error("module size not written");
    a_noise_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_acc && paddr == OFF_CFG2_HI |=> red_group_noise_setting == $past(pwdata[7])) // R10
        else $error("noise bit not written");
endmodule : ledcfg_regs

/* rtl/ledcfg_store.sv */
// Purpose: Holds the two 48-bit configuration words
// Assumes: Caller merges partial writes before strobing
// Notes: Reserved bits are forced back to reset image on every write
module ledcfg_store (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Store side
    ledcfg_if.store cfg
);
    import ledcfg_pkg::*;
    logic [WORD_W-1:0] cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt;

    always_comb begin
        cfg1_nxt = cfg1_r;
        cfg2_nxt = cfg2_r;
        if (cfg.we1) begin
            cfg1_nxt = (cfg.wdata & CFG1_WMASK) | (CFG1_RESET & ~CFG1_WMASK); // R11
        end
        if (cfg.we2) begin
            cfg2_nxt = (cfg.wdata & CFG2_WMASK) | (CFG2_RESET & ~CFG2_WMASK); // R11
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cfg1_r <= CFG1_RESET;
            cfg2_r <= CFG2_RESET;
        end else begin
            cfg1_r <= cfg1_nxt;
            cfg2_r <= cfg2_nxt;
        end
    end

    assign cfg.cfg1 = cfg1_r;
    assign cfg.cfg2 = cfg2_r;

    a_reserved_held: assert property (@(posedge ref_clk) disable iff (!rstn)
        ((cfg1_r & ~CFG1_WMASK) == (CFG1_RESET & ~CFG1_WMASK))
        && ((cfg2_r & ~CFG2_WMASK) == (CFG2_RESET & ~CFG2_WMASK))) // R11
        else $error("reserved bits changed");
    a_value_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
        !cfg.we1 && !cfg.we2 |=> $stable(cfg1_r) && $stable(cfg2_r)) // R11
        else $error("config changed without write");
endmodule : ledcfg_store

/* verification/ledcfg_regs_bench.sv */
// Purpose: Self-checking bench for the scan timing and colour configuration registers
// Assumes: Zero wait state APB slave; halves of each word at base and base+4
// Notes: Model words rebuilt from writes; reserved bits always return their reset image
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ledcfg_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ledcfg_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [10:0] segment_clock_count;
    logic [8:0] scan_line_switch_time, subperiod_limit;
    logic [5:0] black_field_clocks, red_lowgray_smoothing, green_lowgray_smoothing;
    logic [5:0] blue_lowgray_smoothing;
    logic [3:0] red_lowgray_boost, green_lowgray_boost, blue_lowgray_boost;
    logic [3:0] red_predischarge_code, green_predischarge_code, blue_predischarge_code;
    logic [3:0] red_decoupling_level, green_decoupling_level, blue_decoupling_level;
    logic [3:0] red_lowgray_compensation, green_lowgray_compensation;
    logic [3:0] blue_lowgray_compensation;
    logic red_group_noise_setting, green_group_noise_setting, blue_group_noise_setting;
    logic module_dimension_select, matrix_power_saving_enable;
    int n_fail = 0;
    int n_checks = 0;
    logic [47:0] m1, m2;
    logic [31:0] seed = 32'hc72d_28f7;
    logic [31:0] rd, r;
    logic err;
    logic [35:0] tbl [11] = '{{4'h0, 32'h0000_007F}, {4'h0, 32'hFFFF_FFFF},
        {4'h0, 32'h0000_03FE}, {4'h4, 32'hFFFF_FE00}, {4'h4, 32'h0000_0020},
        {4'h4, 32'h0000_01E0}, {4'hC, 32'hFFFF_FFFF}, {4'hC, 32'h0000_0000},
        {4'h8, 32'hFFFF_FFFF}, {4'h1, 32'hFFFF_FFFF}, {4'hE, 32'h0000_1234}};

    ledcfg_regs dut (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .segment_clock_count, .scan_line_switch_time,
        .black_field_clocks, .red_lowgray_smoothing, .green_lowgray_smoothing,
        .blue_lowgray_smoothing, .red_lowgray_boost, .green_lowgray_boost,
        .blue_lowgray_boost, .red_predischarge_code, .green_predischarge_code,
        .blue_predischarge_code, .red_decoupling_level, .green_decoupling_level,
        .blue_decoupling_level, .red_lowgray_compensation, .green_lowgray_compensation,
        .blue_lowgray_compensation, .red_group_noise_setting, .green_group_noise_setting,
        .blue_group_noise_setting, .subperiod_limit, .module_dimension_select,
        .matrix_power_saving_enable);

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Reserved bits are rebuilt from the reset image, so the model ignores them too
    function automatic logic [47:0] merge(input logic [47:0] old, input logic [47:0] rst,
            input logic [47:0] msk, input logic hi, input logic [31:0] d);
        logic [47:0] n;
        n = old;
        if (hi) n[47:32] = d[15:0];
        else n[31:0] = d;
        return (n & msk) | (rst & ~msk);
    endfunction : merge

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic chk_out();
        int lsw;
        lsw = (m1[40:37] == 4'h0) ? 45 : (int'(m1[40:37]) + 1) * 30;
        `CHK(segment_clock_count, (m1[9:0] == 10'h3FF) ? 11'h400 : 11'h080)
        `CHK(red_lowgray_smoothing, 6'(m1[14:10]) + 6'h01)
        `CHK(green_lowgray_smoothing, 6'(m1[19:15]) + 6'h01)
        `CHK(blue_lowgray_smoothing, 6'(m1[24:20]) + 6'h01)
        `CHK({red_lowgray_boost, green_lowgray_boost, blue_lowgray_boost},
            {m1[28:25], m1[32:29], m1[36:33]})
        `CHK(scan_line_switch_time, 9'(lsw))
        `CHK(black_field_clocks, m1[46:41])
        `CHK(red_predischarge_code, m2[3:0])
        `CHK({blue_predischarge_code, green_predischarge_code}, m2[11:4])
        `CHK(subperiod_limit, m2[42] ? 9'h100 : 9'h080)
        `CHK(module_dimension_select, m2[43])
        `CHK({blue_group_noise_setting, green_group_noise_setting,
            red_group_noise_setting}, m2[41:39])
        `CHK({blue_decoupling_level, green_decoupling_level, red_decoupling_level,
            blue_lowgray_compensation, green_lowgray_compensation,
            red_lowgray_compensation, matrix_power_saving_enable},
            {m2[23:20], m2[19:16], m2[15:12], m2[35:32], m2[31:28], m2[27:24], m2[47]})
    endtask : chk_out

    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK(err, a[1:0] != 2'b00)
        if (wr && a[1:0] == 2'b00) begin
            if (a[3]) m2 = merge(m2, CFG2_RESET, CFG2_WMASK, a[2], d);
            else m1 = merge(m1, CFG1_RESET, CFG1_WMASK, a[2], d);
        end
        if (!wr) begin
            case (a)
                4'h0: `CHK(rd, m1[31:0])
                4'h4: `CHK(rd, {16'h0000, m1[47:32]})
                4'h8: `CHK(rd, m2[31:0])
                4'hC: `CHK(rd, {16'h0000, m2[47:32]})
                default: `CHK(rd, 32'h0000_0000)
            endcase
        end
        @(negedge ref_clk);
        chk_out();
    endtask : xfer

    task automatic read_all();
        for (int a = 0; a < 16; a += 4) xfer(1'b0, 4'(a), 32'h0000_0000);
    endtask : read_all

    initial begin
        m1 = CFG1_RESET;
        m2 = CFG2_RESET;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        read_all();
        // Reset levels straight from the rules, independent of the shared reset image
        `CHK(segment_clock_count, 11'h080)
        `CHK(green_lowgray_smoothing, 6'h0A)
        `CHK(blue_lowgray_smoothing, 6'h0A)
        `CHK(scan_line_switch_time, 9'h0F0)
        `CHK({green_predischarge_code, red_predischarge_code}, 8'h66)
        `CHK(blue_predischarge_code, 4'h6)
        `CHK({blue_group_noise_setting, red_group_noise_setting}, 2'h3)
        $display("test reset_values done");
        foreach (tbl[i]) begin
            xfer(1'b1, tbl[i][35:32], tbl[i][31:0]);
            xfer(1'b0, tbl[i][35:32], 32'h0000_0000);
        end
        $display("test boundary_codes done");
        repeat (60) begin
            r = xs();
            xfer(1'b1, {r[3:2], r[1:0] & {2{r[4]}}}, xs());
            xfer(1'b0, {r[3:2], r[1:0] & {2{r[5]}}}, 32'h0000_0000);
        end
        $display("test random_access done");
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        m1 = CFG1_RESET;
        m2 = CFG2_RESET;
        read_all();
        $display("test mid_run_reset done");
        stop_test();
    end
endmodule : ledcfg_regs_bench
